/* File: rtl/opg_top.sv */
`timescale 1ns/100ps

module opg_top #(
  parameter int DLY_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        remote_onoff_i,
  input  wire logic [3:0]  setpoint_strap_pin_i,
  input  wire logic        strap_disable_i,
  input  wire logic [15:0] stored_vcmd_i,
  input  wire logic [15:0] vout_sample_i,
  input  wire logic        vout_valid_i,
  input  wire logic        calib_done_i,
  input  wire logic        ramp_done_i,
  output logic             output_enable_o,
  output logic      [15:0] target_mv_o,
  output logic      [7:0]  gain_o,
  output logic      [7:0]  damping_ratio_setting_o,
  output logic             neg_duty_o,
  output logic             regulation_ok_output_o,
  output logic             regulation_ok_output_oe_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] pct(input logic [15:0] v, input logic [15:0] p);
    logic [31:0] t;
    t = 32'(v) * 32'(p);
    return 16'(t / 32'd100);
  endfunction

  function automatic logic [15:0] strap_mv(input logic [3:0] c);
    case (c)
      4'h0:    strap_mv = 16'h0258;
      4'h1:    strap_mv = 16'h02BC;
      4'h2:    strap_mv = 16'h02EE;
      4'h3:    strap_mv = 16'h0320;
      4'h4:    strap_mv = 16'h0352;
      4'h5:    strap_mv = 16'h0384;
      4'h6:    strap_mv = 16'h03B6;
      4'h7:    strap_mv = 16'h03E8;
      4'h8:    strap_mv = 16'h041A;
      4'h9:    strap_mv = 16'h044C;
      4'hA:    strap_mv = 16'h04B0;
      4'hB:    strap_mv = 16'h05DC;
      4'hC:    strap_mv = 16'h0708;
      4'hD:    strap_mv = 16'h09C4;
      4'hE:    strap_mv = 16'h0CE4;
      default: strap_mv = 16'h1388;
    endcase
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [2:0] pin_sync_q;
  logic       pin_q;
  logic [3:0] strap_s1_q;
  logic [3:0] strap_s2_q;
  logic [3:0] strap_s3_q;
  logic [3:0] strap_q;

  always_ff @(posedge clk_i) begin
    pin_sync_q <= {pin_sync_q[1:0], remote_onoff_i};
    strap_s1_q <= setpoint_strap_pin_i;
    strap_s2_q <= strap_s1_q;
    strap_s3_q <= strap_s2_q;
  end

  // strap code counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (strap_s2_q == strap_s3_q)
      strap_q <= strap_s3_q;
  end

  // change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i)
      pin_q <= 1'b1;
    else if (pin_sync_q[1] == pin_sync_q[2])
      pin_q <= pin_sync_q[2];
  end

  // ----------------------------------------
  // init: strap capture once after reset
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_LOAD = 3'b010,
    ST_RUN  = 3'b100
  } opg_init_t;

  opg_init_t   st_q;
  logic [1:0]  wait_q;
  logic [15:0] nom_q;

  // reset only clears state; strap is taken by clock after release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= ST_WAIT;
      wait_q <= 2'h0;
    end else begin
      case (st_q)
        ST_WAIT: begin
          wait_q <= wait_q + 2'h1;
          if (wait_q == 2'h3)
            st_q <= ST_LOAD;
        end
        ST_LOAD: st_q <= ST_RUN;
        ST_RUN:  st_q <= ST_RUN;
        default: st_q <= ST_WAIT;
      endcase
    end
  end

  wire logic [15:0] nom_src = strap_disable_i ? stored_vcmd_i
                                              : strap_mv(strap_q);
  wire logic        init_done = (st_q == ST_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i)
      nom_q <= 16'h0000;
    else if (st_q == ST_LOAD)
      nom_q <= nom_src;
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [2:0]  ctrl_q;
  logic [7:0]  oper_q;
  logic [15:0] vcmd_q;
  logic [15:0] trim_q;
  logic [15:0] mhi_q;
  logic [15:0] mlo_q;
  logic [15:0] vmax_q;
  logic [15:0] ovl_q;
  logic [15:0] uvl_q;
  logic [15:0] pgon_q;
  logic [15:0] pgoff_q;
  logic [1:0]  ovr_q;
  logic [1:0]  uvr_q;
  logic [7:0]  gain_q;
  logic [7:0]  zeta_q;
  logic        ndc_q;
  logic        ack_q;
  logic [31:0] rdat_q;

  wire logic [7:0] adr  = wb_adr_i[7:0];
  wire logic       req  = wb_cyc_i && wb_stb_i && !ack_q;
  wire logic       wr   = req && wb_we_i && wb_sel_i[0];
  wire logic       clr  = wr && (adr == opg_pkg::ADR_STATUS) && wb_dat_i[opg_pkg::CLR_FAULT_BIT];
  wire logic [15:0] wd  = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_dat_i[7:0]};

  always_ff @(posedge clk_i) begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= opg_pkg::CTRL_RST;
      oper_q <= opg_pkg::OPER_RST;
      gain_q <= opg_pkg::GAIN_RST;
      zeta_q <= opg_pkg::ZETA_RST;
      ndc_q  <= 1'b0;
      ovr_q  <= opg_pkg::RSP_RST;
      uvr_q  <= opg_pkg::RSP_RST;
      trim_q <= 16'h0000;
    end else if (wr) begin
      case (adr)
        opg_pkg::ADR_CTRL:  ctrl_q <= wb_dat_i[2:0];
        opg_pkg::ADR_OPER:  oper_q <= wb_dat_i[7:0];
        opg_pkg::ADR_TRIM:  trim_q <= wd;
        opg_pkg::ADR_OVRSP: ovr_q  <= wb_dat_i[1:0];
        opg_pkg::ADR_UVRSP: uvr_q  <= wb_dat_i[1:0];
        opg_pkg::ADR_LOOP: begin
          gain_q <= wb_dat_i[15:8];
          zeta_q <= wb_dat_i[23:16];
          ndc_q  <= wb_dat_i[opg_pkg::NDC_BIT];
        end
        default: ;
      endcase
    end
  end

  // voltage registers default from the loaded nominal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vcmd_q  <= 16'h0000;
      mhi_q   <= 16'h0000;
      mlo_q   <= 16'h0000;
      vmax_q  <= 16'h0000;
      ovl_q   <= 16'h0000;
      uvl_q   <= 16'h0000;
      pgon_q  <= 16'h0000;
      pgoff_q <= 16'h0000;
    end else if (st_q == ST_LOAD) begin
      vcmd_q  <= nom_src;
      mhi_q   <= pct(nom_src, opg_pkg::PCT_MHI);
      mlo_q   <= pct(nom_src, opg_pkg::PCT_MLO);
      vmax_q  <= (pct(nom_src, opg_pkg::PCT_VMAX) < opg_pkg::VABS_MAX_MV) ?
                 pct(nom_src, opg_pkg::PCT_VMAX) : opg_pkg::VABS_MAX_MV;
      ovl_q   <= pct(nom_src, opg_pkg::PCT_OV);
      uvl_q   <= pct(nom_src, opg_pkg::PCT_UV);
      pgon_q  <= pct(nom_src, opg_pkg::PCT_PGON);
      pgoff_q <= pct(nom_src, opg_pkg::PCT_PGOFF);
    end else if (wr) begin
      case (adr)
        opg_pkg::ADR_VCMD:  vcmd_q  <= wd;
        opg_pkg::ADR_MHI:   mhi_q   <= wd;
        opg_pkg::ADR_MLO:   mlo_q   <= wd;
        opg_pkg::ADR_VMAX:  vmax_q  <= wd;
        opg_pkg::ADR_OVLIM: ovl_q   <= wd;
        opg_pkg::ADR_UVLIM: uvl_q   <= wd;
        opg_pkg::ADR_PGON:  pgon_q  <= wd;
        opg_pkg::ADR_PGOFF: pgoff_q <= wd;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // target path
  // ----------------------------------------
  wire logic [1:0]  mrg     = oper_q[opg_pkg::OPER_MRG_LO +: 2];
  wire logic [15:0] base_mv = (mrg == 2'h2) ? mhi_q :
                              (mrg == 2'h1) ? mlo_q : vcmd_q;
  wire logic [16:0] sum_mv  = {1'b0, base_mv} + {trim_q[15], trim_q};
  // negative sums saturate to zero rather than wrap high
  wire logic [15:0] trim_mv = sum_mv[16] ? 16'h0000 : sum_mv[15:0];
  wire logic [15:0] tgt_d   = (trim_mv > vmax_q) ? vmax_q : trim_mv;

  // ----------------------------------------
  // enable and faults
  // ----------------------------------------
  wire logic pin_on  = ctrl_q[opg_pkg::ONOFF_POL_BIT] ? !pin_q : pin_q;
  wire logic bus_on  = oper_q[opg_pkg::OPER_ON_BIT];
  logic      req_on;

  always_comb begin
    case (opg_pkg::opg_src_t'(ctrl_q[opg_pkg::ONOFF_SRC_LO +: 2]))
      opg_pkg::OPG_SRC_PIN:  req_on = pin_on;
      opg_pkg::OPG_SRC_BUS:  req_on = bus_on;
      opg_pkg::OPG_SRC_BOTH: req_on = pin_on && bus_on;
      opg_pkg::OPG_SRC_ON:   req_on = 1'b1;
      default:               req_on = pin_on;
    endcase
  end

  // per-sample comparisons
  logic      ov_hold_q;
  logic      uv_hold_q;
  wire logic ov_cmp = vout_sample_i > ovl_q;
  wire logic uv_cmp = ramp_done_i && (vout_sample_i < uvl_q);
  // level holds between samples so delay counts and retry see a steady fault
  wire logic ov_now = vout_valid_i ? ov_cmp : ov_hold_q;
  wire logic uv_now = ramp_done_i && (vout_valid_i ? uv_cmp : uv_hold_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_hold_q <= 1'b0;
      uv_hold_q <= 1'b0;
    end else if (vout_valid_i) begin
      ov_hold_q <= ov_cmp;
      uv_hold_q <= uv_cmp;
    end
  end

  opg_pkg::opg_flt_t flt_q;
  logic [DLY_W-1:0]  ov_cnt_q;
  logic [DLY_W-1:0]  uv_cnt_q;
  logic              ov_act_q;
  logic              uv_act_q;
  logic              ov_st_q;
  logic              uv_st_q;
  logic [DLY_W-1:0]  dly_q;
  logic              req_on_q;

  wire logic restart = req_on && !req_on_q;

  // fault response per kind; set beats clear
  function automatic logic [1:0] rsp_step(input logic [1:0] r, input logic now,
                                          input logic lat, input logic cnt_end,
                                          input logic clear);
    logic off;
    logic l;
    off = 1'b0;
    l   = lat && !clear;
    case (opg_pkg::opg_rsp_t'(r))
      opg_pkg::OPG_RSP_IGNORE: off = 1'b0;
      opg_pkg::OPG_RSP_DELAY:  begin if (now && cnt_end) l = 1'b1; off = l; end
      opg_pkg::OPG_RSP_LATCH:  begin if (now) l = 1'b1; off = l; end
      opg_pkg::OPG_RSP_RETRY:  off = now;
      default:                 off = now;
    endcase
    return {l, off};
  endfunction

  wire logic [1:0] ov_s = rsp_step(ovr_q, ov_now, ov_st_q, ov_cnt_q >= dly_q,
                                   clr || restart);
  wire logic [1:0] uv_s = rsp_step(uvr_q, uv_now, uv_st_q, uv_cnt_q >= dly_q,
                                   clr || restart);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_cnt_q <= '0;
      uv_cnt_q <= '0;
      ov_st_q  <= 1'b0;
      uv_st_q  <= 1'b0;
      ov_act_q <= 1'b0;
      uv_act_q <= 1'b0;
      req_on_q <= 1'b0;
      dly_q    <= '1;
    end else begin
      ov_cnt_q <= ov_now ? ov_cnt_q + 1'b1 : '0;
      uv_cnt_q <= uv_now ? uv_cnt_q + 1'b1 : '0;
      ov_st_q  <= ov_s[1];
      uv_st_q  <= uv_s[1];
      ov_act_q <= ov_s[0];
      uv_act_q <= uv_s[0];
      req_on_q <= req_on;
      if (wr && adr == opg_pkg::ADR_STATUS)
        dly_q <= wb_dat_i[16 +: DLY_W];
    end
  end

  always_comb begin
    flt_q.ov         = ov_now;
    flt_q.uv         = uv_now;
    flt_q.ov_latched = ov_st_q;
    flt_q.uv_latched = uv_st_q;
  end

  wire logic en_d = init_done && req_on && !ov_act_q && !uv_act_q;

  // ----------------------------------------
  // power good
  // ----------------------------------------
  logic pg_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_d || ov_now || uv_now)
      pg_q <= 1'b0;
    else if (vout_valid_i && vout_sample_i < pgoff_q)
      pg_q <= 1'b0;
    else if (vout_valid_i && vout_sample_i > pgon_q && calib_done_i && ramp_done_i)
      pg_q <= 1'b1;
  end

  // ----------------------------------------
  // outputs and read mux
  // ----------------------------------------
  logic        en_q;
  logic [15:0] tgt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q  <= 1'b0;
      tgt_q <= 16'h0000;
    end else begin
      en_q  <= en_d;
      tgt_q <= tgt_d;
    end
  end

  logic [31:0] rmux;

  always_comb begin
    case (adr)
      opg_pkg::ADR_CTRL:   rmux = {29'h0, ctrl_q};
      opg_pkg::ADR_OPER:   rmux = {24'h0, oper_q};
      opg_pkg::ADR_VCMD:   rmux = {16'h0, vcmd_q};
      opg_pkg::ADR_TRIM:   rmux = {16'h0, trim_q};
      opg_pkg::ADR_MHI:    rmux = {16'h0, mhi_q};
      opg_pkg::ADR_MLO:    rmux = {16'h0, mlo_q};
      opg_pkg::ADR_VMAX:   rmux = {16'h0, vmax_q};
      opg_pkg::ADR_OVLIM:  rmux = {16'h0, ovl_q};
      opg_pkg::ADR_UVLIM:  rmux = {16'h0, uvl_q};
      opg_pkg::ADR_PGON:   rmux = {16'h0, pgon_q};
      opg_pkg::ADR_PGOFF:  rmux = {16'h0, pgoff_q};
      opg_pkg::ADR_OVRSP:  rmux = {30'h0, ovr_q};
      opg_pkg::ADR_UVRSP:  rmux = {30'h0, uvr_q};
      opg_pkg::ADR_LOOP:   rmux = {8'h0, zeta_q, gain_q, 7'h0, ndc_q};
      opg_pkg::ADR_STATUS: rmux = {24'h0, pg_q, en_q, init_done, 1'b0, flt_q};
      opg_pkg::ADR_TARGET: rmux = {nom_q, tgt_q};
      default:             rmux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      rdat_q <= 32'h0000_0000;
    else if (req)
      rdat_q <= rmux;
  end

  assign wb_ack_o                  = ack_q;
  assign wb_dat_o                  = rdat_q;
  assign output_enable_o           = en_q;
  assign target_mv_o               = tgt_q;
  assign gain_o                    = gain_q;
  assign damping_ratio_setting_o   = zeta_q;
  assign neg_duty_o                = ndc_q;
  assign regulation_ok_output_o    = 1'b0;
  assign regulation_ok_output_oe_o = pg_q;  // open drain: high enable pulls low

endmodule

/* File: inc/opg_pkg.sv */
package opg_pkg;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_OPER     = 8'h04;
  localparam logic [7:0] ADR_VCMD     = 8'h08;
  localparam logic [7:0] ADR_TRIM     = 8'h0C;
  localparam logic [7:0] ADR_MHI      = 8'h10;
  localparam logic [7:0] ADR_MLO      = 8'h14;
  localparam logic [7:0] ADR_VMAX     = 8'h18;
  localparam logic [7:0] ADR_OVLIM    = 8'h1C;
  localparam logic [7:0] ADR_UVLIM    = 8'h20;
  localparam logic [7:0] ADR_PGON     = 8'h24;
  localparam logic [7:0] ADR_PGOFF    = 8'h28;
  localparam logic [7:0] ADR_OVRSP    = 8'h2C;
  localparam logic [7:0] ADR_UVRSP    = 8'h30;
  localparam logic [7:0] ADR_LOOP     = 8'h34;
  localparam logic [7:0] ADR_STATUS   = 8'h38;
  localparam logic [7:0] ADR_TARGET   = 8'h3C;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ONOFF_SRC_LO  = 0;
  localparam int ONOFF_POL_BIT = 2;
  localparam int OPER_ON_BIT   = 7;
  localparam int OPER_MRG_LO   = 4;
  localparam int CLR_FAULT_BIT = 8;
  localparam int NDC_BIT       = 0;

  // ----------------------------------------
  // reset values; voltages in mV
  // ----------------------------------------
  localparam logic [15:0] VABS_MAX_MV  = 16'h157C;
  localparam logic [7:0]  GAIN_RST     = 8'h08;
  localparam logic [7:0]  ZETA_RST     = 8'h18;
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam logic [7:0]  OPER_RST     = 8'h00;
  localparam logic [1:0]  RSP_RST      = 2'h3;
  localparam logic [15:0] PCT_MHI      = 16'h0069;
  localparam logic [15:0] PCT_MLO      = 16'h005F;
  localparam logic [15:0] PCT_VMAX     = 16'h006E;
  localparam logic [15:0] PCT_OV       = 16'h0073;
  localparam logic [15:0] PCT_UV       = 16'h0055;
  localparam logic [15:0] PCT_PGON     = 16'h005A;
  localparam logic [15:0] PCT_PGOFF    = 16'h0055;

  localparam int          STRAP_LEVELS = 16;

  typedef enum logic [1:0] {
    OPG_RSP_IGNORE  = 2'h0,
    OPG_RSP_DELAY   = 2'h1,
    OPG_RSP_LATCH   = 2'h2,
    OPG_RSP_RETRY   = 2'h3
  } opg_rsp_t;

  typedef enum logic [1:0] {
    OPG_SRC_PIN  = 2'h0,
    OPG_SRC_BUS  = 2'h1,
    OPG_SRC_BOTH = 2'h2,
    OPG_SRC_ON   = 2'h3
  } opg_src_t;

  typedef struct packed {
    logic        ov;
    logic        uv;
    logic        ov_latched;
    logic        uv_latched;
  } opg_flt_t;

endpackage

/* File: test/opg_plant.sv */
`timescale 1ns/100ps
module opg_plant (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] target_mv_i,
  input  wire logic [15:0] offset_i,
  output logic      [15:0] vout_sample_o,
  output logic             vout_valid_o
);
  // ------
  // sense adc: one sample every four clocks
  // ------
  logic [1:0] cnt_q;
  wire        fire = (cnt_q == 2'h3);
  // between samples the bus toggles, so a stale value is never mistaken for data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q         <= 2'h0;
      vout_valid_o  <= 1'b0;
      vout_sample_o <= 16'h0000;
    end else begin
      cnt_q         <= cnt_q + 2'h1;
      vout_valid_o  <= fire;
      vout_sample_o <= fire ? target_mv_i + offset_i : ~vout_sample_o;
    end
  end
endmodule

/* File: test/opg_top_assertions.sv */
`timescale 1ns/100ps
module opg_top_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        calib_done_i,
  input wire logic        ramp_done_i,
  input wire logic        output_enable_o,
  input wire logic [15:0] target_mv_o,
  input wire logic [7:0]  gain_o,
  input wire logic [7:0]  damping_ratio_setting_o,
  input wire logic        regulation_ok_output_o,
  input wire logic        regulation_ok_output_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ------
  // bus handshake
  // ------
  a_ack_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // ------
  // reset state and regulation
  // ------
  a_reset_loop: assert property ($fell(rst_i) |->
    gain_o == opg_pkg::GAIN_RST && damping_ratio_setting_o == opg_pkg::ZETA_RST)
    else $error("loop settings wrong after reset");
  a_reset_outs: assert property ($fell(rst_i) |->
    !output_enable_o && !regulation_ok_output_oe_o && target_mv_o == 16'h0000)
    else $error("outputs wrong after reset");
  a_pg_data_low: assert property (regulation_ok_output_o == 1'b0)
    else $error("open drain data not low");
  a_pg_startup: assert property (!ramp_done_i && !regulation_ok_output_oe_o
    |=> !regulation_ok_output_oe_o)
    else $error("power good rose during ramp");
  a_pg_rise: assert property ($rose(regulation_ok_output_oe_o) |->
    $past(calib_done_i) && $past(ramp_done_i))
    else $error("power good rose without calibration");
  a_target_max: assert property (target_mv_o <= opg_pkg::VABS_MAX_MV)
    else $error("target above absolute clamp");
endmodule

bind opg_top opg_top_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .calib_done_i(calib_done_i), .ramp_done_i(ramp_done_i),
  .output_enable_o(output_enable_o), .target_mv_o(target_mv_o), .gain_o(gain_o),
  .damping_ratio_setting_o(damping_ratio_setting_o),
  .regulation_ok_output_o(regulation_ok_output_o),
  .regulation_ok_output_oe_o(regulation_ok_output_oe_o));

/* File: test/tb_opg_top.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_opg_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        ack;
  logic        pin = 1'b1;
  logic [3:0]  strap = 4'hE;
  logic        sdis = 1'b0;
  logic [15:0] svcmd = 16'h04B0;
  logic [15:0] vout;
  logic        vvalid;
  logic        calib = 1'b0;
  logic        ramp = 1'b0;
  logic [15:0] ofs = 16'h0000;
  logic        en;
  logic [15:0] tgt;
  logic [7:0]  gain;
  logic [7:0]  zeta;
  logic        ndc;
  logic        pgd;
  logic        pgoe;
  int          miscompares = 0;
  int          checks_done = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  opg_top #(.DLY_W(8)) u_dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .remote_onoff_i(pin), .setpoint_strap_pin_i(strap),
    .strap_disable_i(sdis), .stored_vcmd_i(svcmd), .vout_sample_i(vout),
    .vout_valid_i(vvalid), .calib_done_i(calib), .ramp_done_i(ramp),
    .output_enable_o(en), .target_mv_o(tgt), .gain_o(gain),
    .damping_ratio_setting_o(zeta), .neg_duty_o(ndc), .regulation_ok_output_o(pgd),
    .regulation_ok_output_oe_o(pgoe));
  opg_plant u_plant (.clk_i(clk), .rst_i(rst), .target_mv_i(tgt), .offset_i(ofs),
    .vout_sample_o(vout), .vout_valid_o(vvalid));
  // ------
  // shared tasks
  // ------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hF, 24'h0, a, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb, we, sel} <= 7'h00;
    if (ack !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  // level waits on enable (s=0) or power good (s=1)
  task automatic await(input logic s, input logic v);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if ((s ? pgoe : en) === v) break;
    end
    if (n == 200) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic t_reinit(input logic [3:0] s, input logic d, input logic [15:0] nom);
    int n;
    {rst, strap, sdis} <= {1'b1, s, d};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (n = 0; n < 20; n++) begin
      bus(1'b0, opg_pkg::ADR_STATUS, 32'h0);
      if (q[5] === 1'b1) break;
    end
    bus(1'b0, opg_pkg::ADR_TARGET, 32'h0);
    `CHK(q[31:16], nom)
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_loop();
    `CHK({gain, zeta}, {opg_pkg::GAIN_RST, opg_pkg::ZETA_RST})
    bus(1'b0, opg_pkg::ADR_LOOP, 32'h0);
    `CHK(q, 32'h00180800)
    bus(1'b1, opg_pkg::ADR_LOOP, 32'h00200C01);
    bus(1'b0, 8'h40, 32'h0);
    `CHK(q, 32'h00000000)
    `CHK({ndc, gain, zeta}, 17'h10C20)
    strap <= 4'h0;
    bus(1'b0, opg_pkg::ADR_TARGET, 32'h0);
    `CHK(q[31:16], 16'h0CE4)
  endtask
  // {ctrl, oper, 2'b0, pin, expected enable}
  logic [15:0] onoff [9] = '{16'h0003, 16'h0000, 16'h4001, 16'h4002, 16'h3001,
                             16'h1801, 16'h1002, 16'h2803, 16'h2800};
  task automatic t_onoff();
    foreach (onoff[i]) begin
      pin <= onoff[i][1];
      bus(1'b1, opg_pkg::ADR_CTRL, {28'h0, onoff[i][15:12]});
      bus(1'b1, opg_pkg::ADR_OPER, {24'h0, onoff[i][11:4]});
      await(1'b0, onoff[i][0]);
      `CHK(en, onoff[i][0])
    end
    pin <= 1'b1;
    bus(1'b1, opg_pkg::ADR_CTRL, 32'h0);
    bus(1'b1, opg_pkg::ADR_OPER, 32'h0);
  endtask
  // {address, data, expected applied target}
  logic [39:0] spt [10] = '{{8'h08, 32'h0BB80BB8}, {8'h0C, 32'h00320BEA},
    {8'h0C, 32'hFFCE0B86}, {8'h0C, 32'h00000BB8}, {8'h04, 32'h00200D89},
    {8'h04, 32'h00100C3F}, {8'h10, 32'h0D000C3F}, {8'h04, 32'h00200D00},
    {8'h04, 32'h00000BB8}, {8'h08, 32'h13880E2E}};
  task automatic t_setpt();
    foreach (spt[i]) begin
      bus(1'b1, spt[i][39:32], {16'h0, spt[i][31:16]});
      repeat (2) @(posedge clk);
      `CHK(tgt, spt[i][15:0])
    end
    bus(1'b1, opg_pkg::ADR_VMAX, 32'h0DAC);
    bus(1'b0, opg_pkg::ADR_VCMD, 32'h0);
    `CHK({q[15:0], tgt}, 32'h13880DAC)
    bus(1'b1, opg_pkg::ADR_VCMD, 32'h0CE4);
  endtask
  task automatic t_pg();
    ramp <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(pgoe, 1'b0)
    calib <= 1'b1;
    await(1'b1, 1'b1);
    `CHK(pgoe, 1'b1)
    ofs <= 16'hFE0C;
    await(1'b1, 1'b0);
    `CHK(pgoe, 1'b0)
    ofs <= 16'h0000;
    bus(1'b1, opg_pkg::ADR_PGOFF, 32'h0C80);
    await(1'b1, 1'b1);
    ofs <= 16'hFF38;
    await(1'b1, 1'b0);
    `CHK(pgoe, 1'b0)
    ofs <= 16'h0000;
  endtask
  task automatic t_ov();
    await(1'b0, 1'b1);
    ofs <= 16'h01F4;
    await(1'b0, 1'b0);
    `CHK({en, pgoe}, 2'b00)
    ofs <= 16'h0000;
    await(1'b0, 1'b1);
    `CHK(en, 1'b1)
    bus(1'b1, opg_pkg::ADR_OVRSP, 32'h2);
    ofs <= 16'h01F4;
    await(1'b0, 1'b0);
    ofs <= 16'h0000;
    repeat (40) @(posedge clk);
    `CHK(en, 1'b0)
    bus(1'b1, opg_pkg::ADR_STATUS, 32'h100);
    await(1'b0, 1'b1);
    `CHK(en, 1'b1)
    bus(1'b1, opg_pkg::ADR_OVRSP, 32'h0);
    ofs <= 16'h01F4;
    repeat (40) @(posedge clk);
    `CHK(en, 1'b1)
    ofs <= 16'h0000;
    bus(1'b1, opg_pkg::ADR_STATUS, 32'h00100000);
    bus(1'b1, opg_pkg::ADR_OVRSP, 32'h1);
    ofs <= 16'h01F4;
    repeat (4) @(posedge clk);
    `CHK(en, 1'b1)
    await(1'b0, 1'b0);
    `CHK(en, 1'b0)
    ofs <= 16'h0000;
  endtask
  initial begin
    t_reinit(4'hE, 1'b0, 16'h0CE4);
    t_loop();
    t_onoff();
    t_setpt();
    t_pg();
    t_ov();
    t_reinit(4'hF, 1'b0, 16'h1388);
    t_reinit(4'h2, 1'b1, 16'h04B0);
    tally_and_finish();
  end
endmodule
